/* src/ldfs_top.sv */
/*
 * Fault supervisor for a multi-string boost LED driver: latches, isolates strings,
 * restarts or cuts on-time on each fault and drives boost, disconnect, sinks and flag.
 * Assumes comparator inputs are asynchronous and the host drives the
 * combined enable/dimming input.
 */
`timescale 1ns/100ps
`include "ldfs_cfg.svh"

// How it works
// - Input overcurrent: off within 3 us, latched.
// - Input overcurrent drops disconnect gate once latched.
// - UVLO rise enables; fall filtered 50 us.
// - Some detectors blanked during startup window.
// - Primary limit truncates on-time only, no flag.
// - Secondary limit kills all, flags, latches.
// - Sense trip kills all, flags, latches.
// - Sink short at first dimming halts soft-start.
// - Isolate option: disable unregulated strings at limit.
// - Shut-all option: any unregulated string latches off.
// - Flag is open-drain, low while faulted.
// - Undervoltage shutdown clears all latched faults.
module ldfs_top #(
    parameter int unsigned CLEAR_CYC = `LDFS_CLEAR_CYC,
    parameter int unsigned UVLO_CYC = `LDFS_UVLO_FILT_CYC
)
(
    input wire logic i_sys_clk, // System clock, 100 MHz.
    input wire logic i_resetn, // Asynchronous reset, active low.
    input wire logic i_en_pwm, // Combined enable/dimming input.
    input wire logic i_uvlo_rise, // Supply above rising threshold.
    input wire logic i_uvlo_fall, // Supply below falling threshold.
    input wire logic i_input_sense_trip, // Input sense over trip.
    input wire logic i_sw_lim1, // Switch current over primary limit.
    input wire logic i_sw_lim2, // Switch current over secondary limit.
    input wire logic i_output_over_limit, // Output overvoltage.
    input wire logic i_shut_all, // Strap: 1 shut-all, 0 isolate.
    input wire logic i_ss_done, // Soft-start finished.
    input wire logic [5:0] i_sink_short, // Sink pin shorted to ground.
    input wire logic [5:0] i_sink_reg, // String in regulation.
    input wire logic i_fault_in, // Fault pin level (unused input).
    input wire logic i_pwm_clk, // Boost cycle start pulse, async.
    output logic o_boost_en, // Boost switch enable.
    output logic o_disc_gate, // Input disconnect switch gate on.
    output logic [5:0] o_sink_en, // Per-string sink enable.
    output logic o_fault_out, // Fault pin output, always low.
    output logic o_fault_oe // Fault pin enable, high pulls low.
);
    localparam int NS = `LDFS_NUM_STRINGS;

    typedef struct packed
    {
        logic [1:0] s_en;
        logic [1:0] s_uvr;
        logic [1:0] s_uvf;
        logic [1:0] s_ocp;
        logic [1:0] s_lim1;
        logic [1:0] s_lim2;
        logic [1:0] s_ovp;
        logic [1:0] s_cyc;
        logic [1:0] s_ss;
        logic [1:0] s_mode;
        logic [NS-1:0] s_short0;
        logic [NS-1:0] s_short1;
        logic [NS-1:0] s_reg0;
        logic [NS-1:0] s_reg1;
        logic cyc_d;
        logic en_d;
        logic powered;
        ldfs_pkg::ldfs_state_t state;
        logic latched;
        logic flag;
        logic on_time;
        logic [NS-1:0] sink_off;
        logic [15:0] blank;
    } ldfs_st_t;

    ldfs_st_t st;
    ldfs_st_t next_st;
    logic uv_done;
    logic clr_done;
    logic en_s;
    logic uvf_s;

    assign en_s = st.s_en[1];
    assign uvf_s = st.s_uvf[1];

    ldfs_lowcnt #(.LIMIT(UVLO_CYC)) u_uv_filt
    (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_level(uvf_s),
        .o_done(uv_done)
    );

    ldfs_lowcnt #(.LIMIT(CLEAR_CYC)) u_clr_cnt
    (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_level(~en_s),
        .o_done(clr_done)
    );

    always_comb
    begin
        logic fatal;
        logic blanked;
        logic [NS-1:0] unreg;
        fatal = 1'b0;
        blanked = 1'b0;
        unreg = '0;
        next_st = st;
        next_st.s_en = {st.s_en[0], i_en_pwm};
        next_st.s_uvr = {st.s_uvr[0], i_uvlo_rise};
        next_st.s_uvf = {st.s_uvf[0], i_uvlo_fall};
        next_st.s_ocp = {st.s_ocp[0], i_input_sense_trip};
        next_st.s_lim1 = {st.s_lim1[0], i_sw_lim1};
        next_st.s_lim2 = {st.s_lim2[0], i_sw_lim2};
        next_st.s_ovp = {st.s_ovp[0], i_output_over_limit};
        next_st.s_cyc = {st.s_cyc[0], i_pwm_clk};
        next_st.s_ss = {st.s_ss[0], i_ss_done};
        next_st.s_mode = {st.s_mode[0], i_shut_all};
        next_st.s_short0 = i_sink_short;
        next_st.s_short1 = st.s_short0;
        next_st.s_reg0 = i_sink_reg;
        next_st.s_reg1 = st.s_reg0;
        next_st.cyc_d = st.s_cyc[1];
        next_st.en_d = en_s;
        if (st.s_uvr[1])
        begin
            next_st.powered = 1'b1;
        end
        if (uv_done)
        begin
            next_st.powered = 1'b0;
        end
        if (st.blank != 16'h0)
        begin
            next_st.blank = st.blank - 16'h1;
            blanked = 1'b1;
        end
        // Primary limit ends on-time; next cycle restarts it.
        if (st.s_lim1[1])
        begin
            next_st.on_time = 1'b0;
        end
        else if (st.s_cyc[1] && !st.cyc_d)
        begin
            next_st.on_time = 1'b1;
        end
        fatal = st.s_ocp[1] | st.s_lim2[1];
        unreg = ~st.s_reg1 & ~st.sink_off;
        case (st.state)
            ldfs_pkg::LDFS_OFF:
            begin
                next_st.sink_off = '0;
                next_st.flag = 1'b0;
                if (st.powered && en_s && !st.en_d)
                begin
                    next_st.blank = 16'(`LDFS_BLANK_CYC);
                    next_st.state = ldfs_pkg::LDFS_START;
                end
            end
            ldfs_pkg::LDFS_START:
            begin
                if (st.s_short1 != '0)
                begin
                    next_st.flag = 1'b1;
                    next_st.state = ldfs_pkg::LDFS_SHORT;
                end
                else if (st.s_ss[1] && !blanked)
                begin
                    next_st.state = ldfs_pkg::LDFS_RUN;
                end
            end
            ldfs_pkg::LDFS_SHORT:
            begin
                if (st.s_short1 == '0)
                begin
                    next_st.flag = 1'b0;
                    next_st.state = ldfs_pkg::LDFS_START;
                end
            end
            ldfs_pkg::LDFS_RUN:
            begin
                if (st.s_ovp[1] && unreg != '0 && !blanked)
                begin
                    next_st.flag = 1'b1;
                    if (st.s_mode[1])
                    begin
                        next_st.sink_off = '1;
                        next_st.latched = 1'b1;
                        next_st.state = ldfs_pkg::LDFS_LATCH;
                    end
                    else
                    begin
                        next_st.sink_off = st.sink_off | unreg;
                    end
                end
            end
            ldfs_pkg::LDFS_LATCH:
            begin
                next_st.flag = 1'b1;
            end
            default:
            begin
                next_st.state = ldfs_pkg::LDFS_OFF;
            end
        endcase
        if (fatal)
        begin
            next_st.latched = 1'b1;
            next_st.flag = 1'b1;
            next_st.state = ldfs_pkg::LDFS_LATCH;
        end
        else if ((clr_done && !en_s) || !next_st.powered)
        begin
            // Clear latches and flag.
            // A stale count is ignored once the enable is back high, so
            // the rising edge that follows a clear still starts the driver.
            next_st.latched = 1'b0;
            next_st.flag = 1'b0;
            next_st.state = ldfs_pkg::LDFS_OFF;
        end
        else if (!en_s && st.state != ldfs_pkg::LDFS_LATCH &&
                 st.state != ldfs_pkg::LDFS_OFF)
        begin
            next_st.state = ldfs_pkg::LDFS_OFF;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_boost_en = (st.state == ldfs_pkg::LDFS_RUN ||
                         st.state == ldfs_pkg::LDFS_START) &&
                        st.on_time && !st.s_ovp[1];
    assign o_disc_gate = st.powered && !st.latched;
    assign o_sink_en = (st.state == ldfs_pkg::LDFS_RUN) ?
                       ~st.sink_off : '0;
    assign o_fault_out = 1'b0;
    assign o_fault_oe = st.flag | st.latched;
endmodule

/* src/ldfs_cfg.svh */
/*
 * Timing counts and string count for the LED driver fault supervisor.
 * Assumes a 100 MHz system clock.
 */
`ifndef LDFS_CFG_SVH
`define LDFS_CFG_SVH
`define LDFS_CLK_MHZ 100
`define LDFS_NUM_STRINGS 6
`define LDFS_OCP_RESP_US 3
`define LDFS_OCP_RESP_CYC ((`LDFS_OCP_RESP_US * `LDFS_CLK_MHZ))
`define LDFS_UVLO_FILT_US 50
`define LDFS_UVLO_FILT_CYC ((`LDFS_UVLO_FILT_US * `LDFS_CLK_MHZ) + 1)
`define LDFS_CLEAR_MS 16
`define LDFS_CLEAR_CYC (`LDFS_CLEAR_MS * 1000 * `LDFS_CLK_MHZ)
`define LDFS_BLANK_CYC 1000
`endif

/* src/ldfs_pkg.sv */
/*
 * Types for the LED driver fault supervisor.
 * Assumes ldfs_cfg.svh is included by the user.
 */
package ldfs_pkg;
    typedef enum logic [2:0]
    {
        LDFS_OFF = 3'h0,
        LDFS_START = 3'h1,
        LDFS_RUN = 3'h3,
        LDFS_LATCH = 3'h2,
        LDFS_SHORT = 3'h6
    } ldfs_state_t;
endpackage

/* src/ldfs_lowcnt.sv */
/*
 * Saturating counter of consecutive cycles a level stays asserted.
 * Assumes the input is already synchronised to i_sys_clk.
 */
`timescale 1ns/100ps
module ldfs_lowcnt #(
    parameter int unsigned LIMIT = 16
)
(
    input wire logic i_sys_clk, // System clock.
    input wire logic i_resetn, // Asynchronous reset, active low.
    input wire logic i_level, // Level being timed.
    output logic o_done // High once LIMIT cycles have passed.
);
    typedef struct packed
    {
        logic [31:0] count;
        logic done;
    } ldfs_cnt_t;

    ldfs_cnt_t st;
    ldfs_cnt_t next_st;

    always_comb
    begin
        next_st = st;
        if (!i_level)
        begin
            next_st.count = 32'h0;
            next_st.done = 1'b0;
        end
        else if (st.count >= LIMIT - 1)
        begin
            next_st.done = 1'b1;
        end
        else
        begin
            next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_done = st.done;
endmodule

/* test/ldfs_sva.sv */
/* Port checker for ldfs_top.
   Assumes the bind at the foot of this file. */
`timescale 1ns/100ps
module ldfs_sva #(
    parameter int unsigned CLEAR_CYC = 200,
    parameter int unsigned UVLO_CYC = 20
)
(
    input wire logic i_sys_clk, // Clock.
    input wire logic i_resetn, // Reset.
    input wire logic i_en_pwm, // Enable.
    input wire logic i_uvlo_fall, // Supply low.
    input wire logic i_input_sense_trip, // Sense trip.
    input wire logic i_sw_lim1, // Limit 1.
    input wire logic i_sw_lim2, // Limit 2.
    input wire logic i_output_over_limit, // Overvoltage.
    input wire logic o_boost_en, // Boost.
    input wire logic o_disc_gate, // Disconnect.
    input wire logic [5:0] o_sink_en, // Sinks.
    input wire logic o_fault_out, // Flag level.
    input wire logic o_fault_oe // Flag enable.
);
    // ==========
    // Properties
    int unsigned low_cnt;
    int unsigned uv_cnt;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);
    // Counts clean low time of the enable and of the supply.
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            low_cnt <= 0;
            uv_cnt <= 0;
        end
        else
        begin
            low_cnt <= (i_en_pwm || i_sw_lim2 || i_input_sense_trip) ? 0
                : low_cnt + ((low_cnt <= CLEAR_CYC + 8) ? 1 : 0);
            uv_cnt <= !i_uvlo_fall ? 0
                : uv_cnt + ((uv_cnt <= UVLO_CYC + 8) ? 1 : 0);
        end
    end
    sequence s_dead;
        o_fault_oe && !o_disc_gate && !o_boost_en && o_sink_en == 6'h00;
    endsequence
    sequence s_held;
        (i_en_pwm && !i_uvlo_fall)[*4] ##0 (o_fault_oe && !o_disc_gate);
    endsequence
    property p_lim2;
        i_sw_lim2 |-> ##[1:4] s_dead;
    endproperty
    a_lim2: assert property (p_lim2) else $error("lim2 kill");
    property p_trip;
        i_input_sense_trip |-> ##[1:4] s_dead;
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip");
    property p_hold;
        s_held |=> o_fault_oe && !o_disc_gate;
    endproperty
    a_hold: assert property (p_hold) else $error("latch lost");
    property p_clear;
        low_cnt > CLEAR_CYC + 4 |-> !o_fault_oe;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear");
    property p_uvlo;
        uv_cnt > UVLO_CYC + 4 |-> !o_disc_gate && !o_fault_oe;
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("uvlo");
    property p_fout;
        o_fault_out == 1'b0;
    endproperty
    a_fout: assert property (p_fout) else $error("flag level");
    property p_lim1;
        (i_sw_lim1 && !i_sw_lim2 && !i_input_sense_trip && !i_uvlo_fall
            && !i_output_over_limit)[*4] ##0 o_disc_gate |=> o_disc_gate;
    endproperty
    a_lim1: assert property (p_lim1) else $error("lim1");
    // The primary limit must end the on-time once it has been synchronised.
    property p_lim1_cut;
        i_sw_lim1 |-> ##3 !o_boost_en;
    endproperty
    a_lim1_cut: assert property (p_lim1_cut) else $error("cut");
    property p_ovp;
        i_output_over_limit[*3] |-> !o_boost_en;
    endproperty
    a_ovp: assert property (p_ovp) else $error("ovp boost");
    property p_dead;
        o_fault_oe && !o_disc_gate |-> o_sink_en == 6'h00 && !o_boost_en;
    endproperty
    a_dead: assert property (p_dead) else $error("not off");
endmodule

bind ldfs_top ldfs_sva #(.CLEAR_CYC(CLEAR_CYC), .UVLO_CYC(UVLO_CYC)) u_sva
(
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_en_pwm(i_en_pwm),
    .i_uvlo_fall(i_uvlo_fall),
    .i_input_sense_trip(i_input_sense_trip),
    .i_sw_lim1(i_sw_lim1),
    .i_sw_lim2(i_sw_lim2),
    .i_output_over_limit(i_output_over_limit),
    .o_boost_en(o_boost_en),
    .o_disc_gate(o_disc_gate),
    .o_sink_en(o_sink_en),
    .o_fault_out(o_fault_out),
    .o_fault_oe(o_fault_oe)
);

/* test/ldfs_host_model.sv */
/* Host model: drives the enable input, resolves the flag wire.
   Assumes tasks are called from the bench. */
`timescale 1ns/100ps
module ldfs_host_model
(
    input wire logic i_sys_clk, // Clock.
    input wire logic i_fault_oe, // Flag pull enable.
    input wire logic i_fault_out, // Flag drive level.
    output logic o_en_pwm, // Enable to device.
    output logic o_flag // Resolved flag wire.
);
    // ==========
    // Host side
    // The wire sits at the pull-up unless the device pulls it.
    assign o_flag = i_fault_oe ? i_fault_out : 1'b1;
    initial o_en_pwm = 1'b0;
    task automatic set_en(input logic v);
        @(posedge i_sys_clk);
        #1;
        o_en_pwm = v;
    endtask
    // Holds the input low to clear a latch.
    task automatic hold_low(input int n);
        set_en(1'b0);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
endmodule

/* test/tb_top.sv */
/* Bench for ldfs_top with a host model.
   Assumes the checker binds itself. */
`timescale 1ns/100ps
module tb_top;
    // ==========
    // Setup
    localparam int unsigned CLR = 200;
    localparam int unsigned UVC = 20;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_en_pwm;
    logic i_fault_in;
    logic i_uvlo_rise = 1'b1, i_uvlo_fall = 1'b0, i_input_sense_trip = 1'b0;
    logic i_sw_lim1 = 1'b0, i_sw_lim2 = 1'b0, i_output_over_limit = 1'b0;
    logic i_shut_all = 1'b1, i_ss_done = 1'b0, i_pwm_clk = 1'b0;
    logic [5:0] i_sink_short = 6'h00, i_sink_reg = 6'h00;
    logic o_boost_en, o_disc_gate, o_fault_out, o_fault_oe;
    logic [5:0] o_sink_en;
    int errors = 0;
    int tests_run = 0;
    ldfs_top #(.CLEAR_CYC(CLR), .UVLO_CYC(UVC)) dut
    (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_en_pwm(i_en_pwm),
        .i_uvlo_rise(i_uvlo_rise),
        .i_uvlo_fall(i_uvlo_fall),
        .i_input_sense_trip(i_input_sense_trip),
        .i_sw_lim1(i_sw_lim1),
        .i_sw_lim2(i_sw_lim2),
        .i_output_over_limit(i_output_over_limit),
        .i_shut_all(i_shut_all),
        .i_ss_done(i_ss_done),
        .i_sink_short(i_sink_short),
        .i_sink_reg(i_sink_reg),
        .i_fault_in(i_fault_in),
        .i_pwm_clk(i_pwm_clk),
        .o_boost_en(o_boost_en),
        .o_disc_gate(o_disc_gate),
        .o_sink_en(o_sink_en),
        .o_fault_out(o_fault_out),
        .o_fault_oe(o_fault_oe)
    );
    ldfs_host_model host (.i_sys_clk(i_sys_clk), .i_fault_oe(o_fault_oe),
        .i_fault_out(o_fault_out), .o_en_pwm(i_en_pwm), .o_flag(i_fault_in));
    initial forever #5 i_sys_clk = ~i_sys_clk;
    // The cycle pulse moves just after a rising edge, like all stimulus.
    initial
    begin
        #6;
        forever #200 i_pwm_clk = ~i_pwm_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // Expected: flag enable, wire, disconnect, sinks; boff wants boost off.
    task automatic chk(input logic [8:0] exp, input logic boff);
        logic [9:0] got;
        got = {o_fault_oe, i_fault_in, o_disc_gate, o_sink_en,
               boff & o_boost_en};
        tests_run++;
        if (got !== {exp, 1'b0})
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, {exp, 1'b0});
        if (got !== {exp, 1'b0})
            errors++;
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_start(input logic shut);
        i_shut_all = shut;
        i_ss_done = 1'b0;
        i_sink_reg = 6'h00;
        host.set_en(1'b1);
        step(100);
        i_output_over_limit = 1'b1;
        i_ss_done = 1'b1;
        step(10);
        i_output_over_limit = 1'b0;
        chk(9'h0c0, 1'b0);
        step(920);
        i_sink_reg = 6'h3f;
        step(10);
        chk(9'h0ff, 1'b0);
        $display("start done");
    endtask
    task automatic t_fatal(input logic trip);
        i_input_sense_trip = trip;
        i_sw_lim2 = !trip;
        step(1);
        i_input_sense_trip = 1'b0;
        i_sw_lim2 = 1'b0;
        step(3);
        chk(9'h100, 1'b1);
        step(50);
        chk(9'h100, 1'b1);
        host.hold_low(CLR - 20);
        chk(9'h100, 1'b1);
        host.hold_low(30);
        chk(9'h0c0, 1'b1);
        $display("fatal done");
    endtask
    task automatic t_lim1();
        i_sw_lim1 = 1'b1;
        step(5);
        chk(9'h0ff, 1'b1);
        i_sw_lim1 = 1'b0;
        $display("limit one done");
    endtask
    task automatic t_short();
        host.hold_low(5);
        i_sink_short = 6'h04;
        host.set_en(1'b1);
        step(5);
        chk(9'h140, 1'b1);
        i_sink_short = 6'h00;
        step(5);
        chk(9'h0c0, 1'b0);
        $display("short done");
    endtask
    task automatic t_open(input logic shut);
        t_start(shut);
        i_sink_reg = 6'h3b;
        i_output_over_limit = 1'b1;
        step(6);
        i_output_over_limit = 1'b0;
        step(2);
        if (shut)
            chk(9'h100, 1'b1);
        else
            chk(9'h17b, 1'b0);
        host.hold_low(CLR + 10);
        $display("open done");
    endtask
    task automatic t_uvlo();
        t_start(1'b1);
        i_uvlo_fall = 1'b1;
        step(UVC - 5);
        i_uvlo_fall = 1'b0;
        step(2);
        chk(9'h0ff, 1'b0);
        i_sw_lim2 = 1'b1;
        step(1);
        i_sw_lim2 = 1'b0;
        i_uvlo_rise = 1'b0;
        i_uvlo_fall = 1'b1;
        step(UVC + 8);
        chk(9'h080, 1'b1);
        i_uvlo_fall = 1'b0;
        i_uvlo_rise = 1'b1;
        step(6);
        chk(9'h0c0, 1'b1);
        $display("uvlo done");
    endtask
    initial
    begin
        step(6);
        i_resetn = 1'b1;
        step(5);
        t_start(1'b1);
        t_lim1();
        t_fatal(1'b0);
        t_start(1'b1);
        t_fatal(1'b1);
        t_short();
        t_open(1'b1);
        t_open(1'b0);
        t_uvlo();
        tally_and_finish();
    end
    initial
    begin
        #900000;
        errors++;
        tally_and_finish();
    end
endmodule
